//--- src/cca_defs.vh
/*
 Constants of the counter channel with limit alarm: host locations,
 control bit positions, reset values and alarm mode codes.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ==========================================================
// Host locations.
// ==========================================================
`define CCA_WORD_BASE 16'h9C71
`define CCA_WORD_STEP 16'h0002
`define CCA_COIL_BASE 16'h0061
`define CCA_COIL_STEP 16'h0004

// ==========================================================
// Control and status bit positions within a channel group.
// ==========================================================
`define CCA_BIT_RUN 2'h0
`define CCA_BIT_CLR 2'h1
`define CCA_BIT_OVF 2'h2
`define CCA_BIT_SPARE 2'h3

// ==========================================================
// Reset values and count maximum.
// ==========================================================
`define CCA_RUN_RST 1'h1
`define CCA_COUNT_RST 32'h0000_0000
`define CCA_COUNT_MAX 32'hFFFF_FFFF

// ==========================================================
// Alarm mode codes.
// ==========================================================
`define CCA_MODE_DISABLE 2'h0
`define CCA_MODE_MOMENT 2'h1
`define CCA_MODE_LATCH 2'h2

`endif

//--- src/cca_pulse_qual.v
/*
 Input pulse qualifier: turns each rising edge of the count input into
 a single-cycle registered pulse.
 Assumes the count input is already synchronous to mclk.
*/
`default_nettype none

module cca_pulse_qual (
   // Clock and reset.
   input wire mclk,
   input wire resetn,
   // Raw input and qualified pulse.
   input wire countIn,
   output reg pulseOut
);

   reg prevIn_r;

   // ==========================================================
   // Rising edge detection.
   // ==========================================================
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prevIn_r <= 1'h0;
         pulseOut <= 1'h0;
      end else begin
         prevIn_r <= countIn;
         pulseOut <= countIn & ~prevIn_r;
      end
   end

endmodule

`default_nettype wire

//--- src/cca_channel.v
/*
 One counter channel: a 32-bit unsigned pulse count with run, clear and
 overflow bits reached at host coil locations, the count readable as two
 word locations, and a limit alarm that can drive a mapped digital output.
 Assumes host strobes are single-cycle and synchronous to mclk.
 Assumes the count input is synchronous to mclk and low for a cycle between pulses.
 Assumes the host reads the two count words separately, so a carry may fall between them.
*/
`default_nettype none
`include "cca_defs.vh"

module cca_channel #(
   parameter [15:0] CHAN = 16'h0000
) (
   // Clock and reset.
   input wire mclk,
   input wire resetn,
   // Counted input.
   input wire countIn,
   // Host coil writes.
   input wire coilWr,
   input wire [15:0] coilAddr,
   input wire coilWrData,
   // Host word reads.
   input wire [15:0] wordAddr,
   output reg [15:0] wordRdData,
   output reg wordHit,
   // Channel bits as read by the host.
   output reg runBit,
   output reg clrBit,
   output reg ovfBit,
   output reg spareBit,
   // Count value.
   output reg [31:0] countVal,
   // Alarm configuration.
   input wire [1:0] alarmMode,
   input wire alarmHigh,
   input wire [31:0] alarmLimit,
   input wire clearLatch,
   input wire doMapEn,
   // Alarm results.
   output reg alarmOn,
   output reg doOut
);

   // ==========================================================
   // Location decode.
   // ==========================================================
   function coilMatch;
      input [15:0] addr;
      input [1:0] bitSel;
      begin
         coilMatch = (addr == (`CCA_COIL_BASE + CHAN * `CCA_COIL_STEP + {14'h0000, bitSel}));
      end
   endfunction

   wire [15:0] wordBase;
   wire pulseQ;
   wire wrRun;
   wire wrClr;
   wire wrOvf;
   wire clearNow;
   wire stepNow;
   wire wrapNow;
   wire limitCross;
   wire latchMode;
   wire aboveLimit;
   wire belowLimit;
   wire [15:0] wordHiAddr;

   // Next values of the output registers.
   reg runBit_nxt;
   reg [31:0] countVal_nxt;
   reg ovfBit_nxt;
   reg [15:0] wordRdData_nxt;
   reg wordHit_nxt;
   reg alarmOn_nxt;
   reg doOut_nxt;

   assign wordBase = `CCA_WORD_BASE + CHAN * `CCA_WORD_STEP;
   assign wordHiAddr = wordBase + 16'h0001;
   assign wrRun = coilWr & coilMatch(coilAddr, `CCA_BIT_RUN);
   assign wrClr = coilWr & coilMatch(coilAddr, `CCA_BIT_CLR);
   assign wrOvf = coilWr & coilMatch(coilAddr, `CCA_BIT_OVF);

   // ==========================================================
   // Pulse qualification.
   // ==========================================================
   cca_pulse_qual uQual (
      .mclk(mclk),
      .resetn(resetn),
      .countIn(countIn),
      .pulseOut(pulseQ)
   );

   // ==========================================================
   // Counter.
   // ==========================================================
   assign clearNow = wrClr & coilWrData;
   assign stepNow = runBit & pulseQ & ~clearNow;
   assign wrapNow = stepNow & (countVal == `CCA_COUNT_MAX);

   always @* begin
      runBit_nxt = runBit;
      countVal_nxt = countVal;
      ovfBit_nxt = ovfBit;
      if (wrRun) begin
         runBit_nxt = coilWrData;
      end
      // A clear write beats a pulse in the same cycle; that pulse is lost.
      if (clearNow) begin
         countVal_nxt = `CCA_COUNT_RST;
      end else if (stepNow) begin
         countVal_nxt = countVal + 32'h0000_0001;
      end
      // A wrap beats a zero write in the same cycle, so no overflow goes unseen.
      if (wrapNow) begin
         ovfBit_nxt = 1'h1;
      end else if (wrOvf & ~coilWrData) begin
         ovfBit_nxt = 1'h0;
      end
   end

   // ==========================================================
   // Counter registers.
   // ==========================================================
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         runBit <= `CCA_RUN_RST;
         clrBit <= 1'h0;
         spareBit <= 1'h0;
         countVal <= `CCA_COUNT_RST;
         ovfBit <= 1'h0;
      end else begin
         runBit <= runBit_nxt;
         // Clear and spare bits keep no state of their own and always read zero.
         clrBit <= 1'h0;
         spareBit <= 1'h0;
         countVal <= countVal_nxt;
         ovfBit <= ovfBit_nxt;
      end
   end

   // ==========================================================
   // Word read next state.
   // ==========================================================
   always @* begin
      wordRdData_nxt = 16'h0000;
      wordHit_nxt = 1'h0;
      if (wordAddr == wordBase) begin
         wordRdData_nxt = countVal[15:0];
         wordHit_nxt = 1'h1;
      end else if (wordAddr == wordHiAddr) begin
         wordRdData_nxt = countVal[31:16];
         wordHit_nxt = 1'h1;
      end
   end

   // ==========================================================
   // Word read registers.
   // ==========================================================
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wordRdData <= 16'h0000;
         wordHit <= 1'h0;
      end else begin
         wordRdData <= wordRdData_nxt;
         wordHit <= wordHit_nxt;
      end
   end

   // ==========================================================
   // Limit alarm.
   // ==========================================================
   assign aboveLimit = (countVal > alarmLimit);
   assign belowLimit = (countVal < alarmLimit);
   assign limitCross = alarmHigh ? aboveLimit : belowLimit;
   // Momentary and unknown codes fall back to disabled on this channel.
   assign latchMode = (alarmMode == `CCA_MODE_LATCH);

   // Set beats clear: the latch holds while the count stays past the limit.
   always @* begin
      alarmOn_nxt = alarmOn;
      if (!latchMode) begin
         alarmOn_nxt = 1'h0;
      end else if (limitCross) begin
         alarmOn_nxt = 1'h1;
      end else if (clearLatch) begin
         alarmOn_nxt = 1'h0;
      end
      doOut_nxt = alarmOn & doMapEn;
   end

   // ==========================================================
   // Alarm registers.
   // ==========================================================
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         alarmOn <= 1'h0;
         doOut <= 1'h0;
      end else begin
         alarmOn <= alarmOn_nxt;
         doOut <= doOut_nxt;
      end
   end

endmodule

`default_nettype wire

//--- bench/cca_channel_chk.sv
/* Port checker of one counter channel.
   Assumes a bind to cca_channel and one clock. */
`default_nettype none
`include "cca_defs.vh"
module cca_channel_chk #(parameter [15:0] CHAN = 16'h0000) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic resetn,
   // Host coil writes.
   input wire logic coilWr,
   input wire logic [15:0] coilAddr,
   input wire logic coilWrData,
   // Host word reads.
   input wire logic [15:0] wordAddr,
   input wire logic [15:0] wordRdData,
   input wire logic wordHit,
   // Channel bits and count.
   input wire logic runBit,
   input wire logic clrBit,
   input wire logic ovfBit,
   input wire logic spareBit,
   input wire logic [31:0] countVal,
   // Alarm configuration and results.
   input wire logic [1:0] alarmMode,
   input wire logic alarmHigh,
   input wire logic [31:0] alarmLimit,
   input wire logic clearLatch,
   input wire logic doMapEn,
   input wire logic alarmOn,
   input wire logic doOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // Checks.
   wire [15:0] cb = `CCA_COIL_BASE + `CCA_COIL_STEP * CHAN;
   wire runW = coilWr && coilAddr == cb;
   wire clrW = coilWr && coilWrData && coilAddr == cb + 16'h0001;
   wire ovfW = coilWr && !coilWrData && coilAddr == cb + 16'h0002;
   wire trip = alarmHigh ? countVal > alarmLimit : countVal < alarmLimit;
   wire latch = alarmMode == `CCA_MODE_LATCH;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   rest_zero_a: assert property (!clrBit && !spareBit) else $error("bit not zero");
   run_write_a: assert property (runW |=> runBit == $past(coilWrData)) else $error("run");
   clr_count_a: assert property (clrW |=> countVal == 0) else $error("clear");
   ovf_clear_a: assert property (
      ovfW && countVal != `CCA_COUNT_MAX |=> !ovfBit) else $error("ovf clear");
   ovf_cause_a: assert property (
      $rose(ovfBit) |-> $past(countVal) == `CCA_COUNT_MAX && countVal == 0) else $error("ovf");
   step_one_a: assert property (
      countVal != $past(countVal) |-> countVal == $past(countVal) + 1 || countVal == 0)
      else $error("step");
   halt_hold_a: assert property (
      !$past(runBit) && countVal != $past(countVal) |-> countVal == 0) else $error("halt");
   alarm_off_a: assert property (!latch |=> !alarmOn) else $error("alarm off");
   alarm_set_a: assert property (latch && trip |=> alarmOn) else $error("alarm set");
   latch_hold_a: assert property (
      latch && alarmOn && !clearLatch |=> alarmOn) else $error("latch");
   do_map_a: assert property (1 |=> doOut == $past(alarmOn && doMapEn)) else $error("do");
   word_read_a: assert property (
      wordAddr == `CCA_WORD_BASE + `CCA_WORD_STEP * CHAN
      |=> wordHit && wordRdData == $past(countVal[15:0])) else $error("word");
   cover property (alarmOn && doOut);
   cover property (clrW);
   cover property (!runBit);
endmodule
bind cca_channel cca_channel_chk #(.CHAN(CHAN)) cca_channel_chk_inst (.*);
`default_nettype wire

//--- bench/cca_host_model.sv
/* Host model issuing single-cycle coil writes.
   Assumes mclk is the channel clock. */
`default_nettype none
module cca_host_model (
   input wire logic mclk,
   output var logic coilWr = 1'b0,
   output var logic coilWrData = 1'b0,
   output var logic [15:0] coilAddr = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // Write cycle; released lines show inverted values.
   task automatic put(input logic [15:0] a, input logic d);
      @(negedge mclk);
      coilWr = 1'b1;
      coilAddr = a;
      coilWrData = d;
      @(negedge mclk);
      coilWr = 1'b0;
      coilAddr = ~a;
      coilWrData = ~d;
   endtask
endmodule
`default_nettype wire

//--- bench/test_counter_channel_with_alarm.sv
/* Bench of counter channel 1 driven through a host model.
   Assumes the checker binds itself to the channel. */
`default_nettype none
`include "cca_defs.vh"
module test_counter_channel_with_alarm;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] CH = 16'h0001;
   localparam logic [15:0] CB = `CCA_COIL_BASE + `CCA_COIL_STEP * CH;
   localparam logic [15:0] WB = `CCA_WORD_BASE + `CCA_WORD_STEP * CH;
   logic mclk = 1'b0, resetn = 1'b0, countIn = 1'b0, alarmHigh = 1'b1, clearLatch = 1'b0;
   logic doMapEn = 1'b1, coilWr, coilWrData, wordHit, runBit, clrBit, ovfBit, spareBit;
   logic alarmOn, doOut;
   logic [15:0] coilAddr, wordRdData, wordAddr = 16'h0000;
   logic [31:0] countVal, alarmLimit = 32'h0000_0000;
   logic [1:0] alarmMode = `CCA_MODE_DISABLE;
   int n_mismatch = 0, checks_done = 0, cyc = 0, n;
   cca_host_model cca_host_model_inst (.*);
   cca_channel #(.CHAN(CH)) cca_channel_inst (.*);
   // =====
   // Helpers.
   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic pulses(input int k);
      repeat (k) begin
         @(negedge mclk) countIn = 1'b1;
         @(negedge mclk) countIn = 1'b0;
      end
      repeat (3) @(negedge mclk);
   endtask
   function automatic logic trip(input logic hi, input logic [31:0] c, input logic [31:0] l);
      return hi ? c > l : c < l;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial forever #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report;
      end
   end
   // =====
   // Tests.
   initial begin
      void'($urandom(32'hd048));
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      chk({runBit, clrBit, ovfBit, spareBit, alarmOn, doOut, countVal}, 38'h20_0000_0000);
      n = $urandom_range(20, 1);
      pulses(n);
      chk(countVal, n);
      wordAddr = WB;
      @(negedge mclk) chk({wordHit, wordRdData}, {1'b1, n[15:0]});
      wordAddr = WB + 16'h0001;
      @(negedge mclk) chk({wordHit, wordRdData}, {1'b1, n[31:16]});
      wordAddr = WB + 16'h0002;
      @(negedge mclk) chk({wordHit, wordRdData}, 0);
      $display("test count done");
      cca_host_model_inst.put(CB, 1'b0);
      pulses(2);
      chk({runBit, countVal}, n);
      cca_host_model_inst.put(CB, 1'b1);
      pulses(1);
      chk(countVal, n + 1);
      cca_host_model_inst.put(CB - 16'h0003, 1'b1);
      cca_host_model_inst.put(CB + 16'h0001, 1'b0);
      chk(countVal, n + 1);
      cca_host_model_inst.put(CB + 16'h0002, 1'b0);
      cca_host_model_inst.put(CB + 16'h0001, 1'b1);
      chk({ovfBit, clrBit, countVal}, 0);
      $display("test control done");
      n = $urandom_range(10, 3);
      pulses(n);
      alarmLimit = n - 1;
      for (int m = 0; m < 4; m++) begin
         alarmMode = m[1:0];
         repeat (3) @(negedge mclk);
         chk({alarmOn, doOut}, {2{m == 2 && trip(alarmHigh, n, alarmLimit)}});
      end
      alarmMode = `CCA_MODE_LATCH;
      repeat (3) @(negedge mclk);
      alarmHigh = 1'b0;
      doMapEn = 1'b0;
      repeat (3) @(negedge mclk);
      chk({alarmOn, doOut}, 2'b10);
      clearLatch = 1'b1;
      @(negedge mclk) clearLatch = 1'b0;
      @(negedge mclk) chk(alarmOn, trip(alarmHigh, n, alarmLimit));
      alarmLimit = n + 1;
      repeat (2) @(negedge mclk);
      chk(alarmOn, trip(alarmHigh, n, alarmLimit));
      $display("test alarm done");
      cca_host_model_inst.put(CB, 1'b0);
      resetn = 1'b0;
      @(negedge mclk) resetn = 1'b1;
      chk({runBit, ovfBit, countVal}, {1'b1, 1'b0, 32'h0000_0000});
      pulses(2);
      chk(countVal, 2);
      $display("test reset done");
      final_report;
   end
endmodule
`default_nettype wire
